/* File: verilog/conv_seq_pkg.sv */
// shared constants for the converter readout sequencer and its host end
package conv_seq_pkg;

    // ----------------------------------------
    // clock and timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int HOST_MCLK_KHZ = 16780; // master clock the queue timing is planned for
    localparam int POST_DELAY_NS = 19000;
    localparam int POST_DELAY_CYC = (POST_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LINK_HALF_CYC = 12; // half period of either link clock
    localparam int CONV_NS = 8000;
    localparam int CONV_CYC = CONV_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 12;

    // ----------------------------------------
    // transfer sizes
    // ----------------------------------------
    localparam int START_BITS = 8;
    localparam int RESULT_BITS = 16;
    localparam int BIT_CNT_W = 5;

    // ----------------------------------------
    // host register map
    // ----------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] CTRL_OFF = 4'h0;
    localparam logic [3:0] STATUS_OFF = 4'h4;
    localparam logic [3:0] MASK_OFF = 4'h8;
    localparam logic [3:0] RESULT_OFF = 4'hc;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_MODE_BIT = 1; // 1: converter paces, 0: host paces
    localparam int EV_DONE_BIT = 0;
    localparam int EV_SYNC_BIT = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam logic [1:0] STATUS_RST = 2'h0;

endpackage

/* File: verilog/conv_link_if.sv */
// link wires between the converter end and the host end
`timescale 1ns/100ps
`default_nettype none
interface conv_link_if;
    logic host_convert_select_line; // low with device select starts a conversion
    logic host_device_select_line;
    logic host_sck;
    logic busy;
    logic dev_sck;
    logic serial_result_out;
    logic [7:0] par_data;
    logic par_oe;
    wire [7:0] par_bus;
    wire parallel_msb_line;

    // released upper parallel byte rests at its pull-up level
    assign par_bus = par_oe ? par_data : 8'hff;
    assign parallel_msb_line = par_bus[7];

    modport device (
        input host_convert_select_line, host_device_select_line, host_sck,
        output busy, dev_sck, serial_result_out, par_data, par_oe
    );
    modport host (
        output host_convert_select_line, host_device_select_line, host_sck,
        input busy, dev_sck, serial_result_out, parallel_msb_line
    );
endinterface
`default_nettype wire

/* File: verilog/conv_device_end.sv */
// converter end: conversion timing, busy, serial and three-state parallel output
`timescale 1ns/100ps
`default_nettype none
module conv_device_end
    import conv_seq_pkg::*;
#(
    parameter int CONV_CYCLES = CONV_CYC,
    parameter int HALF_CYCLES = LINK_HALF_CYC
) (
    input wire logic clk_i,
    input wire logic reset_i,
    conv_link_if.device link,
    input wire logic self_paced_i,
    input wire logic [15:0] sample_i,
    output logic [15:0] result_o,
    output logic conv_done_o
);

    typedef enum logic [1:0] {
        D_IDLE = 2'b00,
        D_CONV = 2'b01,
        D_SHIFT = 2'b10
    } dev_state_e;

    dev_state_e state_reg, state_next;
    logic [2:0] sync1_reg, sync2_reg, prev_reg;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [BIT_CNT_W-1:0] bits_reg, bits_next;
    logic [15:0] hold_reg, hold_next, shreg_reg, shreg_next, result_reg, result_next;
    logic busy_reg, busy_next, dsck_reg, dsck_next, sout_reg, sout_next;
    logic done_reg, done_next;
    logic conv_low, sel_low, both_low, both_low_prev, read_win, read_win_prev, sck_fall;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // two flops on each host pin, third flop for edges
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sync1_reg <= 3'h7;
            sync2_reg <= 3'h7;
            prev_reg <= 3'h7;
        end else begin
            sync1_reg <= {link.host_sck == 1'b0, link.host_convert_select_line,
                          link.host_device_select_line};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    // decoded control levels and edges
    assign conv_low = ~sync2_reg[1];
    assign sel_low = ~sync2_reg[0];
    assign both_low = conv_low & sel_low;
    assign both_low_prev = ~prev_reg[1] & ~prev_reg[0];
    assign read_win = sel_low & ~conv_low;
    assign read_win_prev = ~prev_reg[0] & prev_reg[1];
    assign sck_fall = sync2_reg[2] & ~prev_reg[2]; // stored inverted

    // ----------------------------------------
    // conversion sequencer
    // ----------------------------------------
    // next state of conversion, shifting and output drivers
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        bits_next = bits_reg;
        hold_next = hold_reg;
        shreg_next = shreg_reg;
        result_next = result_reg;
        busy_next = busy_reg;
        dsck_next = dsck_reg;
        sout_next = sout_reg;
        done_next = 1'b0;
        case (state_reg)
            D_IDLE: begin
                busy_next = 1'b1;
                dsck_next = 1'b0;
                if (self_paced_i || (both_low && !both_low_prev)) begin // R07
                    state_next = D_CONV;
                    hold_next = sample_i;
                    cnt_next = '0;
                    busy_next = 1'b0;
                end else if (read_win && sck_fall) begin // R08
                    shreg_next = {shreg_reg[14:0], 1'b0};
                end else if (!read_win && read_win_prev) begin
                    shreg_next = result_reg; // rearm for another read
                end
            end
            D_CONV: begin
                if (cnt_reg == CNT_W'(CONV_CYCLES - 1)) begin
                    busy_next = 1'b1; // R03
                    result_next = hold_reg;
                    shreg_next = hold_reg;
                    done_next = 1'b1;
                    cnt_next = '0;
                    bits_next = '0;
                    state_next = self_paced_i ? D_SHIFT : D_IDLE;
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            D_SHIFT: begin
                if (cnt_reg == CNT_W'(HALF_CYCLES - 1)) begin
                    cnt_next = '0;
                    dsck_next = ~dsck_reg;
                    if (!dsck_reg) begin
                        // data changes on the rising link edge
                        sout_next = shreg_reg[15];
                        shreg_next = {shreg_reg[14:0], 1'b0};
                        bits_next = bits_reg + 1'b1;
                    end else if (bits_reg == BIT_CNT_W'(RESULT_BITS)) begin
                        state_next = D_CONV; // self paced: next conversion
                        hold_next = sample_i;
                        busy_next = 1'b0;
                    end
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            default: begin
                state_next = D_IDLE;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg <= D_IDLE;
            cnt_reg <= '0;
            bits_reg <= '0;
            hold_reg <= 16'h0000;
            shreg_reg <= 16'h0000;
            result_reg <= 16'h0000;
            busy_reg <= 1'b1;
            dsck_reg <= 1'b0;
            sout_reg <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            bits_reg <= bits_next;
            hold_reg <= hold_next;
            shreg_reg <= shreg_next;
            result_reg <= result_next;
            busy_reg <= busy_next;
            dsck_reg <= dsck_next;
            sout_reg <= sout_next;
            done_reg <= done_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    // upper byte floats unless selected for read
    assign link.par_oe = read_win && !self_paced_i && state_reg == D_IDLE; // R06 R11
    assign link.par_data = shreg_reg[15:8]; // R05
    assign link.busy = busy_reg;
    assign link.dev_sck = dsck_reg;
    assign link.serial_result_out = sout_reg;
    assign result_o = result_reg;
    assign conv_done_o = done_reg;

endmodule
`default_nettype wire

/* File: verilog/conv_host_end.sv */
// host end: two-entry transfer queue, slave readout and status registers
//
// Behaviour
// R01 - converter paced: host is slave, sample falling
// R02 - arm only after busy rises low to high
// R03 - busy rises when a conversion finishes
// R04 - queue timing planned for 16.78 MHz clock; delays here are counted for a 20 ns clock
// R05 - read result through parallel msb line
// R06 - both control lines high when not converting
// R07 - 8-bit transfer drives both lines low
// R08 - 16-bit transfer drives only select low
// R09 - 19 us delay after each transfer
// R10 - queue wraps to first entry continuously
// R11 - parallel outputs three-state when not read
// R12 - result is second transfer, msb first
//
// Chosen here: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
module conv_host_end
    import conv_seq_pkg::*;
#(
    parameter int POST_DELAY = POST_DELAY_CYC,
    parameter int HALF_CYCLES = LINK_HALF_CYC
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic irq_o,
    conv_link_if.host link
);

    typedef enum logic [2:0] {
        H_IDLE = 3'b000,
        H_START = 3'b001,
        H_DLY1 = 3'b010,
        H_READ = 3'b011,
        H_DLY2 = 3'b100,
        H_WAIT_SYNC = 3'b101,
        H_SLAVE = 3'b110
    } host_state_e;

    host_state_e state_reg, state_next;
    logic [3:0] sync1_reg, sync2_reg, prev_reg;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic [BIT_CNT_W-1:0] bits_reg, bits_next;
    logic [15:0] shift_reg, shift_next, result_reg, result_next;
    logic [1:0] ctrl_reg, ctrl_next, mask_reg, mask_next, status_reg, status_next;
    logic [31:0] rdata_reg, rdata_next;
    logic sck_reg, sck_next, conv_n_reg, conv_n_next, sel_n_reg, sel_n_next;
    logic ev_done, ev_sync;
    logic busy_rise, dsck_fall, serial_bit, msb_bit;
    logic half_done, enabled, conv_paced;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    // two flops on each converter pin, third flop for edges
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sync1_reg <= 4'h1;
            sync2_reg <= 4'h1;
            prev_reg <= 4'h1;
        end else begin
            sync1_reg <= {link.parallel_msb_line, link.serial_result_out,
                          link.dev_sck, link.busy};
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    // edges and data seen after synchronising
    assign busy_rise = sync2_reg[0] & ~prev_reg[0];
    assign dsck_fall = ~sync2_reg[1] & prev_reg[1];
    assign serial_bit = sync2_reg[2];
    assign msb_bit = sync2_reg[3];
    assign half_done = cnt_reg == CNT_W'(HALF_CYCLES - 1);
    assign enabled = ctrl_reg[CTRL_EN_BIT];
    assign conv_paced = ctrl_reg[CTRL_MODE_BIT];

    // ----------------------------------------
    // transfer sequencer
    // ----------------------------------------
    // queue of two transfers, delays, and slave capture
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        bits_next = bits_reg;
        shift_next = shift_reg;
        result_next = result_reg;
        sck_next = sck_reg;
        ev_done = 1'b0;
        ev_sync = 1'b0;
        case (state_reg)
            H_IDLE: begin
                cnt_next = '0;
                bits_next = '0;
                sck_next = 1'b0;
                if (enabled && conv_paced) begin
                    state_next = H_WAIT_SYNC; // R02
                end else if (enabled) begin
                    state_next = H_START; // R04
                end
            end
            H_START, H_READ: begin
                if (half_done) begin
                    cnt_next = '0;
                    sck_next = ~sck_reg;
                    if (!sck_reg) begin
                        // sample on the rising edge this host makes
                        shift_next = {shift_reg[14:0], msb_bit}; // R05
                    end else begin
                        bits_next = bits_reg + 1'b1;
                        if (state_reg == H_START
                            && bits_reg == BIT_CNT_W'(START_BITS - 1)) begin
                            state_next = H_DLY1; // R12
                            bits_next = '0;
                        end else if (state_reg == H_READ
                            && bits_reg == BIT_CNT_W'(RESULT_BITS - 1)) begin
                            state_next = H_DLY2;
                            bits_next = '0;
                            result_next = shift_reg; // R12
                            ev_done = 1'b1;
                        end
                    end
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            H_DLY1, H_DLY2: begin
                if (cnt_reg == CNT_W'(POST_DELAY - 1)) begin // R09
                    cnt_next = '0;
                    if (!enabled || conv_paced) begin
                        state_next = H_IDLE;
                    end else if (state_reg == H_DLY1) begin
                        state_next = H_READ;
                    end else begin
                        state_next = H_START; // R10
                    end
                end else begin
                    cnt_next = cnt_reg + 1'b1;
                end
            end
            H_WAIT_SYNC: begin
                bits_next = '0;
                if (!enabled || !conv_paced) begin
                    state_next = H_IDLE;
                end else if (busy_rise) begin
                    state_next = H_SLAVE; // R02
                    ev_sync = 1'b1;
                end
            end
            H_SLAVE: begin
                if (!enabled || !conv_paced) begin
                    state_next = H_IDLE;
                end else if (dsck_fall) begin
                    shift_next = {shift_reg[14:0], serial_bit}; // R01
                    bits_next = bits_reg + 1'b1;
                    if (bits_reg == BIT_CNT_W'(RESULT_BITS - 1)) begin
                        result_next = {shift_reg[14:0], serial_bit};
                        ev_done = 1'b1;
                        state_next = H_WAIT_SYNC;
                    end
                end
            end
            default: begin
                state_next = H_IDLE;
            end
        endcase
        // control lines follow the next state
        conv_n_next = state_next != H_START; // R07
        sel_n_next = !(state_next == H_START || state_next == H_READ); // R06 R08
    end

    // sequencer registers
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            state_reg <= H_IDLE;
            cnt_reg <= '0;
            bits_reg <= '0;
            shift_reg <= 16'h0000;
            result_reg <= 16'h0000;
            sck_reg <= 1'b0;
            conv_n_reg <= 1'b1;
            sel_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            bits_reg <= bits_next;
            shift_reg <= shift_next;
            result_reg <= result_next;
            sck_reg <= sck_next;
            conv_n_reg <= conv_n_next;
            sel_n_reg <= sel_n_next;
        end
    end

    // ----------------------------------------
    // register port
    // ----------------------------------------
    // writes, sticky status with read clear, read data
    always_comb begin
        ctrl_next = ctrl_reg;
        mask_next = mask_reg;
        status_next = status_reg;
        rdata_next = 32'h0000_0000;
        if (wr_i && addr_i == CTRL_OFF) begin
            ctrl_next = wdata_i[1:0];
        end
        if (wr_i && addr_i == MASK_OFF) begin
            mask_next = wdata_i[1:0];
        end
        if (rd_i) begin
            case (addr_i)
                CTRL_OFF: rdata_next = {30'h0, ctrl_reg};
                STATUS_OFF: begin
                    rdata_next = {30'h0, status_reg};
                    status_next = 2'h0;
                end
                MASK_OFF: rdata_next = {30'h0, mask_reg};
                RESULT_OFF: rdata_next = {16'h0000, result_reg};
                default: rdata_next = 32'h0000_0000;
            endcase
        end
        // a new event wins over the read clear
        if (ev_done) begin
            status_next[EV_DONE_BIT] = 1'b1;
        end
        if (ev_sync) begin
            status_next[EV_SYNC_BIT] = 1'b1;
        end
    end

    // register file flops
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            ctrl_reg <= CTRL_RST;
            mask_reg <= MASK_RST;
            status_reg <= STATUS_RST;
            rdata_reg <= 32'h0000_0000;
        end else begin
            ctrl_reg <= ctrl_next;
            mask_reg <= mask_next;
            status_reg <= status_next;
            rdata_reg <= rdata_next;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign rdata_o = rdata_reg;
    assign irq_o = |(status_reg & mask_reg);
    assign link.host_sck = sck_reg;
    assign link.host_convert_select_line = conv_n_reg;
    assign link.host_device_select_line = sel_n_reg;

endmodule
`default_nettype wire

/* File: verif/conv_link_chk.sv */
// concurrent checks on the link wires between the two ends
`timescale 1ns/100ps
`default_nettype none
module conv_link_chk #(
    parameter int CONV_CYCLES = 400
) (
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic host_convert_select_line,
    input wire logic host_device_select_line,
    input wire logic host_sck,
    input wire logic busy,
    input wire logic dev_sck,
    input wire logic serial_result_out,
    input wire logic par_oe
);
    localparam int BUSY_MIN = CONV_CYCLES - 3;
    localparam int BUSY_MAX = CONV_CYCLES + 3;
    logic sck_reg, sck_next, sck_rise;
    logic [4:0] start_cnt_reg, start_cnt_next, read_cnt_reg, read_cnt_next;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    // ----------------------------------------
    // link clock rises inside each transfer
    // ----------------------------------------
    always_comb begin
        sck_rise = host_sck && !sck_reg;
        sck_next = host_sck;
        start_cnt_next = host_convert_select_line ? 5'h00 : start_cnt_reg + {4'h0, sck_rise};
        read_cnt_next = (host_device_select_line || !host_convert_select_line) ? 5'h00
                        : read_cnt_reg + {4'h0, sck_rise};
    end

    // register the counters
    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            sck_reg <= 1'b0;
            start_cnt_reg <= 5'h00;
            read_cnt_reg <= 5'h00;
        end else begin
            sck_reg <= sck_next;
            start_cnt_reg <= start_cnt_next;
            read_cnt_reg <= read_cnt_next;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_idle_tristate: assert property (
        (host_convert_select_line && host_device_select_line) [*8] |-> !par_oe)
        else $error("parallel msb driven while both selects high");
    a_read_drives: assert property (
        (!host_device_select_line && host_convert_select_line && busy) [*6] |-> par_oe)
        else $error("parallel msb not driven during result read");
    a_start_busy: assert property (
        $fell(host_device_select_line) && !host_convert_select_line && busy
        |-> ##[1:6] $fell(busy))
        else $error("conversion did not start after both selects fell");
    a_busy_span: assert property (
        $fell(busy) |-> ##[BUSY_MIN:BUSY_MAX] $rose(busy))
        else $error("busy did not rise at conversion end");
    a_sck_idle: assert property (
        host_sck |-> !host_device_select_line)
        else $error("host link clock high outside a transfer");
    a_dev_sck_busy: assert property (
        dev_sck |-> busy)
        else $error("device link clock high during conversion");
    a_start_len: assert property (
        $rose(host_convert_select_line) |-> start_cnt_reg == 5'h08)
        else $error("start transfer not eight clocks long");
    a_read_len: assert property (
        $rose(host_device_select_line) && $past(host_convert_select_line)
        |-> read_cnt_reg == 5'h10)
        else $error("read transfer not sixteen clocks long");
    a_post_gap: assert property (
        $rose(host_device_select_line)
        |-> (host_device_select_line && host_convert_select_line) [*8])
        else $error("no gap after a transfer");
    a_serial_holds: assert property (
        $fell(dev_sck) |-> $stable(serial_result_out))
        else $error("serial bit changed at sampling edge");
endmodule
`default_nettype wire

/* File: verif/test_converter_serial_readout_sequencer.sv */
// testbench joining converter end and host end across the link
`timescale 1ns/100ps
`default_nettype none
module test_converter_serial_readout_sequencer
    import conv_seq_pkg::*;
;
    localparam int CONV_N = 100;
    localparam int DELAY_N = 20;
    logic clk_i, reset_i, wr_i, rd_i, self_paced_i, irq_o, conv_done_o;
    logic [ADDR_W-1:0] addr_i;
    logic [31:0] wdata_i, rdata_o, rd_val;
    logic [15:0] sample_i, result_o;
    int errors, check_count, done_seen;
    logic [15:0] samples [2] = '{16'h8001, 16'h7ffe};
    logic [3:0] offs [5] = '{CTRL_OFF, STATUS_OFF, MASK_OFF, RESULT_OFF, 4'h2};

    conv_link_if link ();
    conv_device_end #(.CONV_CYCLES(CONV_N), .HALF_CYCLES(LINK_HALF_CYC)) i_conv_device_end (
        .clk_i(clk_i), .reset_i(reset_i), .link(link), .self_paced_i(self_paced_i),
        .sample_i(sample_i), .result_o(result_o), .conv_done_o(conv_done_o));
    conv_host_end #(.POST_DELAY(DELAY_N), .HALF_CYCLES(LINK_HALF_CYC)) i_conv_host_end (
        .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .link(link));
    conv_link_chk #(.CONV_CYCLES(CONV_N)) i_conv_link_chk (
        .clk_i(clk_i), .reset_i(reset_i),
        .host_convert_select_line(link.host_convert_select_line),
        .host_device_select_line(link.host_device_select_line), .host_sck(link.host_sck),
        .busy(link.busy), .dev_sck(link.dev_sck), .serial_result_out(link.serial_result_out),
        .par_oe(link.par_oe));

    // count conversion end pulses from the converter end
    always @(posedge clk_i) begin
        if (reset_i) begin
            done_seen <= 0;
        end else if (conv_done_o === 1'b1) begin
            done_seen <= done_seen + 1;
        end
    end

    // free running clock
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end

    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    task automatic wait_irq();
        int n = 0;
        while (irq_o !== 1'b1 && n < 4000) begin
            @(posedge clk_i);
            #1;
            n++;
        end
        if (irq_o !== 1'b1) begin
            check("irq_o", {31'h0, irq_o}, 32'h1);
            conclude();
        end
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        reset_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 4'h0;
        wdata_i = 32'h0;
        self_paced_i = 1'b0;
        sample_i = 16'ha5c3;
        errors = 0;
        check_count = 0;
        repeat (3) @(posedge clk_i);
        reset_i <= 1'b0;
        // reset values and an unmapped hole
        foreach (offs[i]) begin
            reg_read(offs[i], rd_val);
            check("reset read", rd_val, 32'h0);
        end
        check("irq_o", {31'h0, irq_o}, 32'h0);
        check("par_oe", {31'h0, link.par_oe}, 32'h0);
        check("msb line", {31'h0, link.parallel_msb_line}, 32'h1);
        // host paced queue, first result
        reg_write(MASK_OFF, 32'h1);
        reg_write(CTRL_OFF, 32'h1);
        reg_read(CTRL_OFF, rd_val);
        check("ctrl", rd_val, 32'h1);
        wait_irq();
        reg_read(STATUS_OFF, rd_val);
        check("status done", rd_val & 32'h1, 32'h1);
        check("irq cleared", {31'h0, irq_o}, 32'h0);
        reg_read(RESULT_OFF, rd_val);
        check("result", rd_val, {16'h0, 16'ha5c3});
        check("result_o", {16'h0, result_o}, {16'h0, 16'ha5c3});
        check("conv_done_o count", done_seen, 32'h1);
        // queue keeps wrapping with fresh samples
        foreach (samples[i]) begin
            @(posedge clk_i);
            sample_i <= samples[i];
            wait_irq();
            reg_read(STATUS_OFF, rd_val);
            wait_irq();
            reg_read(RESULT_OFF, rd_val);
            check("wrapped result", rd_val, {16'h0, samples[i]});
        end
        // masked event stays sticky without interrupt
        reg_write(MASK_OFF, 32'h0);
        reg_read(STATUS_OFF, rd_val);
        repeat (1500) @(posedge clk_i);
        #1;
        check("irq masked", {31'h0, irq_o}, 32'h0);
        reg_read(STATUS_OFF, rd_val);
        check("status sticky", rd_val & 32'h1, 32'h1);
        // converter paced readout
        reg_write(CTRL_OFF, 32'h0);
        repeat (1500) @(posedge clk_i);
        self_paced_i <= 1'b1;
        sample_i <= 16'h3c69;
        reg_write(MASK_OFF, 32'h3);
        reg_write(CTRL_OFF, 32'h3);
        reg_read(STATUS_OFF, rd_val);
        wait_irq();
        reg_read(STATUS_OFF, rd_val);
        check("status sync", rd_val & 32'h2, 32'h2);
        repeat (1200) @(posedge clk_i);
        reg_read(RESULT_OFF, rd_val);
        check("paced result", rd_val, {16'h0, 16'h3c69});
        check("paced result_o", {16'h0, result_o}, {16'h0, 16'h3c69});
        conclude();
    end
endmodule
`default_nettype wire
